// ===== rtl/rsc_defines.vh
// Purpose: constants for the reverse-subtract carry unit
// Assumes: 32-bit datapath, 125 MHz core clock
// Notes: opcode codes and register offsets are local encodings
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH
`define RSC_XLEN 32
`define RSC_IMM_W 16
`define RSC_OP_W 2
`define RSC_OP_CARRYING 2'h0
`define RSC_OP_EXTENDED 2'h1
`define RSC_OP_IMMEDIATE 2'h2
`define RSC_ADDR_W 4
`define RSC_REG_XER 4'h0
`define RSC_REG_CR0 4'h4
`define RSC_REG_RESULT 4'h8
`define RSC_XER_CA 0
`define RSC_XER_OV 1
`define RSC_XER_SO 2
`define RSC_CR0_SO 0
`define RSC_CR0_EQ 1
`define RSC_CR0_GT 2
`define RSC_CR0_LT 3
`define RSC_XER_RESET 3'h0
`define RSC_CR0_RESET 4'h0
`endif

// ===== rtl/rsc_adder.v
// Purpose: three-input adder of inverted first source, second operand and carry-in
// Assumes: combinational, 32-bit operands
// Notes: carry and signed overflow come from the same sum
`timescale 1ns/1ps
`include "rsc_defines.vh"
module rsc_adder (
	input wire [`RSC_XLEN-1:0] first_src_gpr,
	input wire [`RSC_XLEN-1:0] addend,
	input wire cin,
	output wire [`RSC_XLEN-1:0] sum,
	output wire adder_cout,
	output wire oflow
);
	wire [`RSC_XLEN-1:0] inv_a;
	wire [`RSC_XLEN:0] full;
	assign inv_a = ~first_src_gpr;
	assign full = {1'b0, inv_a} + {1'b0, addend} + {{`RSC_XLEN{1'b0}}, cin};
	assign sum = full[`RSC_XLEN-1:0];
	assign adder_cout = full[`RSC_XLEN];
	// signed overflow: like-signed inputs, unlike-signed sum
	assign oflow = (inv_a[`RSC_XLEN-1] == addend[`RSC_XLEN-1]) &&
		(sum[`RSC_XLEN-1] != inv_a[`RSC_XLEN-1]);
endmodule

// ===== rtl/rsc_cr0_gen.v
// Purpose: derives condition field 0 from a signed result
// Assumes: combinational
// Notes: summary overflow bit copies the updated sticky flag
`timescale 1ns/1ps
`include "rsc_defines.vh"
module rsc_cr0_gen (
	input wire [`RSC_XLEN-1:0] result,
	input wire so_in,
	output wire [3:0] cr0
);
	wire zero_flag;
	wire negative_flag;
	wire positive_flag;
	assign zero_flag = (result == {`RSC_XLEN{1'b0}});
	assign negative_flag = result[`RSC_XLEN-1];
	assign positive_flag = ~negative_flag & ~zero_flag;
	assign cr0 = {negative_flag, positive_flag, zero_flag, so_in};
endmodule

// ===== rtl/rsc_unit.v
// Purpose: reverse-subtract family with carry, flag and condition field update
// Assumes: decoder drives one-cycle op_valid with operands; plain register port
// Notes: result written back one cycle after op_valid
//
// What this block does
// - carrying form writes inverted first source plus second source plus one.
// - every carrying and extended form updates the carry flag.
// - overflow-enable set on a carrying or extended form updates overflow and sticky overflow, else unchanged.
// - record bit set writes negative, positive, zero, summary bits of field 0.
// - extended form adds stored carry, second source and inverted first source.
// - immediate form adds inverted first source, one, sign-extended 16-bit immediate.
// - immediate of minus one yields exactly the inverse of the first source.
// - immediate form has one form and never touches condition field 0.
// - immediate form always updates the carry flag.
// - legacy aliases behave identically, four forms chosen by overflow and record bits.
// - operands and results are 32-bit two's-complement for signed flags.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "rsc_defines.vh"
module rsc_unit (
	input wire core_clk,
	input wire rst_n,
	input wire op_valid,
	input wire [`RSC_OP_W-1:0] op_kind,
	input wire legacy_reverse_sub_carrying,
	input wire oe_flag,
	input wire record_flag,
	input wire [4:0] dest_gpr_index,
	input wire [`RSC_XLEN-1:0] first_src_gpr,
	input wire [`RSC_XLEN-1:0] second_src_gpr,
	input wire [`RSC_IMM_W-1:0] imm_value,
	input wire [`RSC_ADDR_W-1:0] reg_addr,
	input wire [`RSC_XLEN-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [`RSC_XLEN-1:0] reg_rdata,
	output reg wb_valid,
	output reg [4:0] wb_index,
	output reg [`RSC_XLEN-1:0] wb_data,
	output reg adder_cout,
	output reg oflow_flag,
	output reg sum_oflow,
	output reg [3:0] cr0
);
	wire [`RSC_XLEN-1:0] addend;
	wire cin;
	wire [`RSC_XLEN-1:0] sum;
	wire add_cout;
	wire add_ov;
	wire so_next;
	wire [3:0] cr0_calc;
	wire is_imm;
	wire op_ok;
	reg [`RSC_XLEN-1:0] last_result_r;

	function [`RSC_XLEN-1:0] sext_imm;
		input [`RSC_IMM_W-1:0] v;
		begin
			sext_imm = {{(`RSC_XLEN-`RSC_IMM_W){v[`RSC_IMM_W-1]}}, v};
		end
	endfunction

	// legacy alias shares the encoding path; it only marks the spelling
	assign op_ok = op_valid && (op_kind != 2'h3);
	assign is_imm = (op_kind == `RSC_OP_IMMEDIATE);
	// immediate -1 plus 1 cancels, leaving ~first_src_gpr exactly
	assign addend = is_imm ? sext_imm(imm_value) : second_src_gpr;
	assign cin = (op_kind == `RSC_OP_EXTENDED) ? adder_cout : 1'b1;

	rsc_adder u_add (
		.first_src_gpr(first_src_gpr),
		.addend(addend),
		.cin(cin),
		.sum(sum),
		.adder_cout(add_cout),
		.oflow(add_ov)
	);

	assign so_next = sum_oflow | (oe_flag && !is_imm && add_ov);

	rsc_cr0_gen u_cr0 (
		.result(sum),
		.so_in(so_next),
		.cr0(cr0_calc)
	);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_valid <= 1'b0;
			wb_index <= 5'h00;
			wb_data <= 32'h0000_0000;
			last_result_r <= 32'h0000_0000;
		end else begin
			wb_valid <= op_ok;
			if (op_ok) begin
				wb_index <= dest_gpr_index;
				wb_data <= sum;
				last_result_r <= sum;
			end
		end
	end

	// flags: instruction update wins over a same-cycle software write
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			adder_cout <= 1'b0;
			oflow_flag <= 1'b0;
			sum_oflow <= 1'b0;
			cr0 <= `RSC_CR0_RESET;
		end else begin
			if (reg_wr && reg_addr == `RSC_REG_XER) begin
				adder_cout <= reg_wdata[`RSC_XER_CA];
				oflow_flag <= reg_wdata[`RSC_XER_OV];
				sum_oflow <= reg_wdata[`RSC_XER_SO];
			end
			if (reg_wr && reg_addr == `RSC_REG_CR0)
				cr0 <= reg_wdata[3:0];
			if (op_ok) begin
				adder_cout <= add_cout;
				if (oe_flag && !is_imm) begin
					oflow_flag <= add_ov;
					sum_oflow <= so_next;
				end
				if (record_flag && !is_imm)
					cr0 <= cr0_calc;
			end
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`RSC_REG_XER: reg_rdata <= {29'h0, sum_oflow, oflow_flag, adder_cout};
				`RSC_REG_CR0: reg_rdata <= {28'h0, cr0};
				`RSC_REG_RESULT: reg_rdata <= last_result_r;
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

// ===== bench/rsc_dec_model.sv
// Purpose: decoder model that presents one operation per call
// Assumes: operation held one cycle, then released
// Notes: operand lines flip while idle so stale values never look valid
`timescale 1ns/1ps
module rsc_dec_model (
	input wire core_clk,
	output reg op_valid, legacy_reverse_sub_carrying, oe_flag, record_flag,
	output reg [1:0] op_kind,
	output reg [4:0] dest_gpr_index,
	output reg [15:0] imm_value,
	output reg [31:0] first_src_gpr, second_src_gpr
);
	initial {op_valid, legacy_reverse_sub_carrying, oe_flag, record_flag, op_kind,
		dest_gpr_index, imm_value, first_src_gpr, second_src_gpr} = 0;
	task issue(input [3:0] c, input [31:0] a, input [31:0] b);
		@(posedge core_clk);
		{op_valid, op_kind, oe_flag, record_flag, first_src_gpr, second_src_gpr, imm_value}
			<= {1'b1, c, a, b, b[15:0]};
		legacy_reverse_sub_carrying <= ~legacy_reverse_sub_carrying;
		dest_gpr_index <= dest_gpr_index + 5'h1;
		@(posedge core_clk);
		op_valid <= 1'b0;
		{first_src_gpr, second_src_gpr} <= ~{a, b};
	endtask
endmodule

// ===== bench/rsc_unit_chk.sv
// Purpose: port checker for the reverse-subtract unit
// Assumes: one clock, reset active low
// Notes: bound to every rsc_unit instance
`timescale 1ns/1ps
module rsc_chk (
	input wire core_clk, rst_n, op_valid, oe_flag, record_flag, wb_valid,
	input wire adder_cout, oflow_flag, sum_oflow,
	input wire [1:0] op_kind,
	input wire [3:0] cr0,
	input wire [31:0] first_src_gpr, second_src_gpr, wb_data
);
	wire [31:0] na = ~first_src_gpr;
	wire [32:0] s0 = na + second_src_gpr + 33'h1;
	wire [32:0] s1 = na + second_src_gpr + adder_cout;
	wire vf = na[31] == second_src_gpr[31] && (op_kind[0] ? s1[31] : s0[31]) != na[31];
	wire sn = vf | sum_oflow;
	wire ar = op_valid && !op_kind[1];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_wb; op_valid && op_kind != 2'h3 |=> wb_valid; endproperty
	a_wb: assert property (p_wb) else $error("result not written");
	property p_nowb; !(op_valid && op_kind != 2'h3) |=> !wb_valid; endproperty
	a_nowb: assert property (p_nowb) else $error("stray result");
	property p_sub; ar && !op_kind[0] |=> {adder_cout, wb_data} == $past(s0); endproperty
	a_sub: assert property (p_sub) else $error("carrying sum wrong");
	property p_ext; ar && op_kind[0] |=> {adder_cout, wb_data} == $past(s1); endproperty
	a_ext: assert property (p_ext) else $error("extended sum wrong");
	property p_ovk; op_valid && !(ar && oe_flag) |=> $stable({oflow_flag, sum_oflow}); endproperty
	a_ovk: assert property (p_ovk) else $error("overflow moved");
	property p_ov; ar && oe_flag |=> oflow_flag == $past(vf) && sum_oflow == $past(sn); endproperty
	a_ov: assert property (p_ov) else $error("overflow wrong");
	property p_crk; op_valid && !(ar && record_flag) |=> $stable(cr0); endproperty
	a_crk: assert property (p_crk) else $error("field 0 moved");
	property p_crw; ar && record_flag |=>
		cr0 == {wb_data[31], !wb_data[31] && |wb_data, ~|wb_data, sum_oflow}; endproperty
	a_crw: assert property (p_crw) else $error("field 0 wrong");
endmodule
bind rsc_unit rsc_chk u_chk (.*);

// ===== bench/tb_rsc_unit.sv
// Purpose: self-checking bench for the reverse-subtract unit
// Assumes: decoder model issues ops, bench drives the register port
// Notes: rows run in order so carry and sticky flags carry over
`timescale 1ns/1ps
module tb_rsc_unit;
	reg core_clk, rst_n, reg_wr, reg_rd;
	reg [3:0] reg_addr;
	reg [31:0] reg_wdata;
	wire op_valid, legacy_reverse_sub_carrying, oe_flag, record_flag, wb_valid;
	wire adder_cout, oflow_flag, sum_oflow;
	wire [1:0] op_kind;
	wire [3:0] cr0;
	wire [4:0] dest_gpr_index, wb_index;
	wire [15:0] imm_value;
	wire [31:0] first_src_gpr, second_src_gpr, reg_rdata, wb_data;
	integer n_mismatch = 0, checks_done = 0, i;
	reg [103:0] rows [0:5];
	rsc_dec_model dec (.*);
	rsc_unit dut (.*);
	task chk(input [47:0] nm, input [31:0] e, input [31:0] g);
		checks_done++;
		n_mismatch += (g !== e);
		if (g !== e) $display("BAD %0s exp %h got %h", nm, e, g);
	endtask
	task acc(input w, input [3:0] ad, input [31:0] d);
		@(posedge core_clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, ad, d};
		@(posedge core_clk);
		{reg_wr, reg_rd} <= 2'h0;
		#1 if (!w) chk("rdata", d, reg_rdata);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial forever #4 core_clk = ~core_clk;
	initial begin
		#2000 n_mismatch++;
		tally_and_finish;
	end
	initial begin
		{core_clk, rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
		rows = '{{4'h2, 32'h80000000, 32'h00004500, 32'h80004500, 4'h6},
			{4'h5, 32'h00004500, 32'h80007000, 32'h80002AFF, 4'h7},
			{4'h7, 32'h80000000, 32'hEFFFFFFF, 32'h6FFFFFFF, 4'h5},
			{4'h8, 32'h90003000, 32'h00007000, 32'h70004000, 4'h4},
			{4'hB, 32'h12345678, 32'h0000FFFF, 32'hEDCBA987, 4'h5},
			{4'hC, 32'h00000001, 32'h00000002, 32'hEDCBA987, 4'h5}};
		repeat (2) @(posedge core_clk);
		#1 chk("reset", 0, {wb_valid, cr0, sum_oflow, oflow_flag, adder_cout});
		$display("reset test done");
		@(posedge core_clk) rst_n <= 1'b1;
		for (i = 0; i < 6; i++) begin
			dec.issue(rows[i][103:100], rows[i][99:68], rows[i][67:36]);
			#1 chk("result", rows[i][35:4], wb_data);
			chk("flags", rows[i][3:0], {sum_oflow, oflow_flag, adder_cout});
			$display("row %0d done", i);
		end
		chk("index", 32'h5, {27'h0, wb_index});
		acc(1'b0, 4'h4, 32'h5);
		acc(1'b1, 4'h0, 32'h0);
		acc(1'b0, 4'h0, 32'h0);
		acc(1'b0, 4'hC, 32'h0);
		acc(1'b1, 4'h4, 32'hA);
		acc(1'b0, 4'h4, 32'hA);
		acc(1'b1, 4'h8, 32'h0);
		acc(1'b0, 4'h8, 32'hEDCBA987);
		$display("register port done");
		@(posedge core_clk) rst_n <= 1'b0;
		@(posedge core_clk);
		#1 chk("reset2", 0, {wb_valid, cr0, sum_oflow, oflow_flag, adder_cout});
		chk("reset2_data", 0, wb_data);
		@(posedge core_clk) rst_n <= 1'b1;
		@(posedge core_clk);
		acc(1'b0, 4'h8, 32'h0);
		$display("mid-run reset test done");
		tally_and_finish;
	end
endmodule
